// File: core/itas_abort_cause.sv
// Transmit-abort cause capture with its control, clear and interrupt registers
`timescale 1ns/1ps
module itas_abort_cause (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // Register port
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [31:0]                rdata_o,
  // Bus pins, sampled only
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  // Controller engines, same clock
  input  wire itas_pkg::itas_mst_evt_t mst_evt_i,
  input  wire itas_pkg::itas_mst_req_t mst_req_i,
  input  wire itas_pkg::itas_slv_t   slv_i,
  // Results
  output logic                       tx_abort_o,
  output logic [15:0]                cause_o,
  output logic                       irq_o
);

  // Stored registers and the combinational next-value and set nets that feed them
  // Narrow flops save area; the bus pads each word with zeros on read
  logic [5:0]              ctrl_r;      // controller_control
  logic [11:0]             tar_r;       // target_address_control
  logic [1:0]              mask_r;      // Interrupt mask
  logic [1:0]              stat_r;      // Sticky interrupt status
  logic [1:0]              stat_nxt;    // Next sticky status
  logic [15:0]             cause_r;     // Abort cause bits
  logic [15:0]             cause_nxt;   // Next cause bits
  logic [15:0]             cause_set;   // Causes raised this cycle
  logic [31:0]             rdata_r;     // Read data, one cycle after strobe
  logic                    abort_r;     // Abort pulse towards FIFO flush
  logic                    irq_r;       // Interrupt level
  itas_pkg::itas_hold_t    hold_r;      // Bit-9 hold sequencer

  // Decoded strobes and conditions
  // Decode is combinational on the register-port clock, except scl_rise and sda_s, which come from synchroniser flops
  logic       scl_rise;       // Synchronised SCL rising edge
  logic       sda_s;          // Synchronised SDA level
  logic       clr_rd;         // Read of either clear register
  logic       stat_rd;        // Read of sticky status
  logic       dcmd_wr;        // Write to data_command_port
  logic       restart_en;     // Restart generation enabled
  logic       sbyte_cond;     // START-byte-without-restart still set up
  logic       hs_mode;        // High-speed selected
  logic       any_set;        // Some cause raised this cycle
  logic       bit9_drop;      // Clear hits an unfixed bit 9

  // SCL edge finder on the block clock
  // The pins lag about three clocks; SDA shares the delay so both stay aligned
  itas_pin_sync u_scl_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (scl_i),
    .level_o    (),
    .rise_o     (scl_rise)
  );

  // SDA level follower, same latency as SCL edge
  // Only the level matters here; the edge output is left open
  itas_pin_sync u_sda_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .pin_i      (sda_i),
    .level_o    (sda_s),
    .rise_o     ()
  );

  // Strobe decode and configuration views
  // Both clear addresses act alike on the cause bits
  always_comb begin
    clr_rd     = rd_i && ((addr_i == itas_pkg::OFS_CLR_ABORT) || (addr_i == itas_pkg::OFS_CLR_ALL));
    stat_rd    = rd_i && (addr_i == itas_pkg::OFS_INT_STAT);
    dcmd_wr    = wr_i && (addr_i == itas_pkg::OFS_DATA_CMD);
    restart_en = ctrl_r[itas_pkg::CTRL_RESTART];
    // Both speed bits set selects high speed
    hs_mode    = (ctrl_r[itas_pkg::CTRL_SPD_HI:itas_pkg::CTRL_SPD_LO] == itas_pkg::SPEED_HIGH);
    // A START byte is requested by the special bit with the start selection
    sbyte_cond = !restart_en && tar_r[itas_pkg::TAR_SPECIAL] && tar_r[itas_pkg::TAR_GENERAL_CALL_OR_START_SELECT];
  end

  // Gather every abort cause raised in this cycle
  // Inputs are one-cycle pulses or levels; nothing here is stored
  always_comb begin
    cause_set = '0;
    cause_set[itas_pkg::C_SLV_RD_INTX] = dcmd_wr && wdata_i[itas_pkg::DCMD_READ] && slv_i.rd_pending;
    // Slave-side causes
    // slave SDA mismatch check
    cause_set[itas_pkg::C_SLV_ARB_LOST] = slv_i.tx_active && scl_rise && (sda_s != slv_i.tx_bit);
    cause_set[itas_pkg::C_SLV_FLUSH] = slv_i.rd_req && !slv_i.txfifo_empty;
    // Bit 14 always brings bit 12 along, so software can tell the roles apart
    // arbitration lost, either role
    cause_set[itas_pkg::C_ARB_LOST] = mst_evt_i.arb_lost || cause_set[itas_pkg::C_SLV_ARB_LOST];
    // Master start checks; a disabled master only ever raises bit 11
    // master disabled
    cause_set[itas_pkg::C_MASTER_DIS] = mst_req_i.valid && !ctrl_r[itas_pkg::CTRL_MST_EN];
    cause_set[itas_pkg::C_TENBIT_RD_NORST] = mst_req_i.valid && ctrl_r[itas_pkg::CTRL_MST_EN] &&
                                             !restart_en && ctrl_r[itas_pkg::CTRL_TENBIT] && mst_req_i.read;
    cause_set[itas_pkg::C_SBYTE_NORST] = mst_req_i.valid && ctrl_r[itas_pkg::CTRL_MST_EN] && sbyte_cond;
    cause_set[itas_pkg::C_HS_NORESTART] = mst_req_i.valid && ctrl_r[itas_pkg::CTRL_MST_EN] &&
                                          !restart_en && hs_mode;
    // Bus-phase results reported by the master engine
    // START byte acknowledged
    cause_set[itas_pkg::C_SBYTE_ACKED] = mst_evt_i.sbyte_acked;
    cause_set[itas_pkg::C_HS_ACKED] = mst_evt_i.hs_code_acked;
    cause_set[itas_pkg::C_GCALL_READ]  = mst_evt_i.gcall_read;
    cause_set[itas_pkg::C_GCALL_NOACK] = mst_evt_i.gcall_noack;
    cause_set[itas_pkg::C_TXDATA_NOACK]   = mst_evt_i.txdata_noack;
    cause_set[itas_pkg::C_ADDR10_2_NOACK] = mst_evt_i.addr10_2_noack;
    cause_set[itas_pkg::C_ADDR10_1_NOACK] = mst_evt_i.addr10_1_noack;
    cause_set[itas_pkg::C_ADDR7_NOACK]    = mst_evt_i.addr7_noack;
    // Any new cause is a transmit abort
    any_set = |cause_set;
  end

  // Next cause value: new causes win over a clear in the same cycle
  // Order matters: clear first, then the bit-9 restore, then new sets
  always_comb begin
    cause_nxt = cause_r;
    bit9_drop = 1'b0;
    if (clr_rd) begin
      // Bit 9 is kept alone here; the lines below decide its fate
      // clear all but bit 9
      cause_nxt = cause_r & (16'h0001 << itas_pkg::C_SBYTE_NORST);
      cause_nxt[itas_pkg::C_SBYTE_NORST] = 1'b0;
      // unfixed bit 9 comes back next cycle
      bit9_drop = cause_r[itas_pkg::C_SBYTE_NORST] && sbyte_cond;
    end
    // bit 9 back after one low cycle
    if (hold_r == itas_pkg::ITAS_HOLD_DROP) begin
      cause_nxt[itas_pkg::C_SBYTE_NORST] = 1'b1;
    end
    // A cause raised during a clear read survives it
    // causes latch with abort flag
    cause_nxt = cause_nxt | cause_set;
  end

  // Cause register; upper half is not stored and reads zero
  // Plain flop copy; every change is decided in the next-value logic
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cause_r <= itas_pkg::CAUSE_RST;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // Bit-9 hold sequencer: one cycle low, then the bit is put back
  // Limitation: the restore does not re-check the cause, so a fix made
  // in the low cycle still sees bit 9 return once
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      hold_r <= itas_pkg::ITAS_HOLD_IDLE;
    end else begin
      case (hold_r)
        itas_pkg::ITAS_HOLD_IDLE: begin
          // Only a clear of an unfixed bit 9 leaves idle
          // start the one-cycle drop
          if (bit9_drop) begin
            hold_r <= itas_pkg::ITAS_HOLD_DROP;
          end
        end
        itas_pkg::ITAS_HOLD_DROP: begin
          // Bit restored this cycle; a further clear may drop it again
          hold_r <= itas_pkg::ITAS_HOLD_IDLE;
        end
        default: begin
          hold_r <= itas_pkg::ITAS_HOLD_IDLE;
        end
      endcase
    end
  end

  // Abort pulse; lets the FIFO logic flush in step with the cause bits
  // The bit-9 restore raises no new pulse; software has already seen it
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= any_set;
    end
  end

  // Writable configuration; reserved and unknown bits are dropped
  // A write lands at the next edge, so a start in that cycle sees old values
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      ctrl_r <= itas_pkg::CTRL_RST;
      tar_r  <= itas_pkg::TAR_RST;
      mask_r <= itas_pkg::MASK_RST;
    end else if (wr_i) begin
      case (addr_i)
        itas_pkg::OFS_CTRL: begin
          ctrl_r <= wdata_i[itas_pkg::CTRL_W-1:0];
        end
        itas_pkg::OFS_TAR: begin
          tar_r <= wdata_i[itas_pkg::TAR_W-1:0];
        end
        itas_pkg::OFS_INT_MASK: begin
          mask_r <= wdata_i[itas_pkg::INT_W-1:0];
        end
        default: begin
          // Read-only and unmapped offsets ignore writes
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Sticky status: raw abort and the bit-9 return, set wins over read clear
  // Bit 0 is the raw abort flag, bit 1 marks a bit-9 return
  // A status read clears both; a clear read touches only bit 0
  always_comb begin
    stat_nxt = stat_r;
    if (stat_rd) begin
      stat_nxt = '0;
    end
    if (clr_rd) begin
      stat_nxt[itas_pkg::INT_TX_ABORT] = 1'b0;
    end
    // Set wins over either clear in the same cycle
    // raw abort flag set
    stat_nxt[itas_pkg::INT_TX_ABORT] = stat_nxt[itas_pkg::INT_TX_ABORT] | any_set;
    stat_nxt[itas_pkg::INT_SBYTE_RE] = stat_nxt[itas_pkg::INT_SBYTE_RE] | (hold_r == itas_pkg::ITAS_HOLD_DROP);
  end

  // Status and interrupt level, both registered
  // The level follows the next status so it moves in step with it
  // A mask write takes one more cycle; the trade keeps irq a plain flop
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      stat_r <= '0;
      irq_r  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  // Read data, valid only in the cycle after the strobe
  // Idle cycles return zero, so a late sample cannot see stale data
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rdata_r <= '0;
    end else if (rd_i) begin
      case (addr_i)
        itas_pkg::OFS_CAUSE:     rdata_r <= {16'h0000, cause_r};
        itas_pkg::OFS_CTRL:      rdata_r <= {26'h0000000, ctrl_r};
        itas_pkg::OFS_TAR:       rdata_r <= {20'h00000, tar_r};
        itas_pkg::OFS_INT_STAT:  rdata_r <= {30'h00000000, stat_r};
        itas_pkg::OFS_INT_MASK:  rdata_r <= {30'h00000000, mask_r};
        // The abort clear returns the flag it is about to clear; the all-clear returns the OR of both status bits
        itas_pkg::OFS_CLR_ABORT: rdata_r <= {31'h00000000, stat_r[itas_pkg::INT_TX_ABORT]};
        itas_pkg::OFS_CLR_ALL:   rdata_r <= {31'h00000000, |stat_r};
        default:                 rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // Outputs straight from flops
  // Upper sixteen cause bits are reserved and never stored
  assign rdata_o    = rdata_r;
  assign tx_abort_o = abort_r;
  assign cause_o    = cause_r;
  assign irq_o      = irq_r;

endmodule

// File: core/itas_pin_sync.sv
// Two-flop pin synchroniser with rising-edge detect on the settled level
`timescale 1ns/1ps
module itas_pin_sync (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Asynchronous pin
  input  wire logic pin_i,
  // Synchronised view
  output logic      level_o,
  output logic      rise_o
);

  logic meta_r;   // First stage, read only by the second
  logic sync_r;   // Settled level
  logic prev_r;   // Previous settled level for edge detect
  logic rise_r;   // Registered edge pulse

  // Two-stage synchroniser; the bus idles high so reset to one
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
    end
  end

  // Edge detect looks only at the settled stage
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      prev_r <= 1'b1;
      rise_r <= 1'b0;
    end else begin
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

  assign level_o = prev_r;
  assign rise_o  = rise_r;

endmodule

// File: core/itas_pkg.sv
// Package with the map, field layout and carriers of the transmit-abort cause block
package itas_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;  // controller_control
  localparam logic [7:0] OFS_TAR       = 8'h04;  // target_address_control
  localparam logic [7:0] OFS_DATA_CMD  = 8'h10;  // data_command_port, write side only
  localparam logic [7:0] OFS_INT_STAT  = 8'h2C;  // Sticky event status, read clears
  localparam logic [7:0] OFS_INT_MASK  = 8'h30;  // Interrupt mask, same layout
  localparam logic [7:0] OFS_CLR_ALL   = 8'h40;  // all_interrupt_clear_on_read
  localparam logic [7:0] OFS_CLR_ABORT = 8'h54;  // abort_clear_on_read
  localparam logic [7:0] OFS_CAUSE     = 8'h80;  // transmit_abort_cause

  // Widths of the stored registers
  localparam int unsigned CAUSE_W = 16;
  localparam int unsigned CTRL_W  = 6;
  localparam int unsigned TAR_W   = 12;
  localparam int unsigned INT_W   = 2;

  // Reset values
  localparam logic [5:0]  CTRL_RST = 6'h21;
  localparam logic [11:0] TAR_RST  = 12'h000;
  localparam logic [1:0]  MASK_RST = 2'h0;
  localparam logic [15:0] CAUSE_RST = 16'h0000;

  // controller_control fields
  localparam int unsigned CTRL_MST_EN  = 0;
  localparam int unsigned CTRL_SPD_LO  = 1;
  localparam int unsigned CTRL_SPD_HI  = 2;
  localparam int unsigned CTRL_TENBIT  = 4;
  localparam int unsigned CTRL_RESTART = 5;
  localparam logic [1:0]  SPEED_HIGH   = 2'h3;

  // target_address_control fields
  localparam int unsigned TAR_GENERAL_CALL_OR_START_SELECT = 10;
  localparam int unsigned TAR_SPECIAL     = 11;

  // data_command_port field
  localparam int unsigned DCMD_READ = 8;

  // Interrupt status fields
  localparam int unsigned INT_TX_ABORT = 0;
  localparam int unsigned INT_SBYTE_RE = 1;

  // Cause bit positions
  localparam int unsigned C_ADDR7_NOACK   = 0;
  localparam int unsigned C_ADDR10_1_NOACK = 1;
  localparam int unsigned C_ADDR10_2_NOACK = 2;
  localparam int unsigned C_TXDATA_NOACK  = 3;
  localparam int unsigned C_GCALL_NOACK   = 4;
  localparam int unsigned C_GCALL_READ    = 5;
  localparam int unsigned C_HS_ACKED      = 6;
  localparam int unsigned C_SBYTE_ACKED   = 7;
  localparam int unsigned C_HS_NORESTART  = 8;
  localparam int unsigned C_SBYTE_NORST   = 9;
  localparam int unsigned C_TENBIT_RD_NORST = 10;
  localparam int unsigned C_MASTER_DIS    = 11;
  localparam int unsigned C_ARB_LOST      = 12;
  localparam int unsigned C_SLV_FLUSH     = 13;
  localparam int unsigned C_SLV_ARB_LOST  = 14;
  localparam int unsigned C_SLV_RD_INTX   = 15;

  // Master bus-phase events, one-cycle pulses from the master engine
  typedef struct packed {
    logic arb_lost;
    logic sbyte_acked;
    logic hs_code_acked;
    logic gcall_read;
    logic gcall_noack;
    logic txdata_noack;
    logic addr10_2_noack;
    logic addr10_1_noack;
    logic addr7_noack;
  } itas_mst_evt_t;

  // Master operation request from the command path
  typedef struct packed {
    logic valid;
    logic read;
  } itas_mst_req_t;

  // Slave transmitter status from the slave engine
  typedef struct packed {
    logic tx_active;    // Driving a data bit on SDA
    logic tx_bit;       // Bit currently being sent
    logic rd_pending;   // Remote master waits for read data
    logic rd_req;       // Pulse: read command just received
    logic txfifo_empty; // Transmit FIFO holds nothing
  } itas_slv_t;

  // Bit-9 hold sequencer states, Gray coded
  typedef enum logic [1:0] {
    ITAS_HOLD_IDLE = 2'b00,
    ITAS_HOLD_DROP = 2'b01
  } itas_hold_t;

endpackage

// File: tb/itas_abort_cause_bench.sv
// Self-checking bench for the transmit-abort cause block
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module itas_abort_cause_bench;
  // Design inputs, all defined at time zero
  logic                    core_clk_i = 1'b0;
  logic                    nrst_i     = 1'b0;
  logic [7:0]              addr_i     = 8'h00;
  logic [31:0]             wdata_i    = 32'h0;
  logic                    wr_i       = 1'b0;
  logic                    rd_i       = 1'b0;
  itas_pkg::itas_mst_evt_t mst_evt_i  = '0;
  itas_pkg::itas_mst_req_t mst_req_i  = '0;
  itas_pkg::itas_slv_t     slv_i      = 5'h01;
  logic                    scl_i;
  logic                    sda_i;
  // Design outputs
  logic [31:0]             rdata_o;
  logic                    tx_abort_o;
  logic [15:0]             cause_o;
  logic                    irq_o;
  // Counters and last read word
  int                      n_mismatch = 0;
  int                      num_checks = 0;
  int                      cyc        = 0;
  logic [31:0]             d;
  // Master request table: control value, read flag, expected cause
  logic [5:0]              req_ctl [5] = '{6'h20, 6'h11, 6'h31, 6'h07, 6'h05};
  logic                    req_rd  [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0]             req_exp [5] = '{16'h0800, 16'h0400, 16'h0000, 16'h0100, 16'h0000};
  // Three ways of removing the start byte cause
  logic [7:0]              fix_a [3] = '{8'h00, 8'h04, 8'h04};
  logic [31:0]             fix_v [3] = '{32'h21, 32'h400, 32'h800};

  itas_abort_cause itas_abort_cause_i (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .scl_i, .sda_i, .mst_evt_i, .mst_req_i, .slv_i, .tx_abort_o, .cause_o, .irq_o);
  itas_bus_model itas_bus_model_i (.scl_o(scl_i), .sda_o(sda_i));

  // 40 MHz core clock
  always #12.5 core_clk_i = ~core_clk_i;

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // One-cycle read strobe; data stand only in the next cycle
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  // Let edges pass and settle
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // Single-cycle pulses of the engines
  task automatic evt(input logic [8:0] v);
    @(posedge core_clk_i);
    mst_evt_i <= v;
    @(posedge core_clk_i);
    mst_evt_i <= '0;
  endtask
  task automatic req(input logic r);
    @(posedge core_clk_i);
    mst_req_i <= {1'b1, r};
    @(posedge core_clk_i);
    mst_req_i <= '0;
  endtask
  task automatic slv(input logic [4:0] v);
    @(posedge core_clk_i);
    slv_i <= v;
    @(posedge core_clk_i);
    slv_i <= 5'h01;
  endtask

  initial begin
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    // Reset values, read-only and unmapped places
    rchk(8'h00, 32'h21);
    rchk(8'h30, 32'h0);
    rchk(8'h80, 32'h0);
    wr(8'h80, 32'h0000FFFF);
    rchk(8'h80, 32'h0);
    rchk(8'hFC, 32'h0);
    wr(8'h04, 32'hFFF);
    rchk(8'h04, 32'hFFF);
    wr(8'h04, 32'h0);
    // Each master event lands on its own bit, both clear addresses
    for (int i = 0; i < 9; i++) begin
      evt(9'h001 << i);
      tick(2);
      rchk(8'h80, (i == 8) ? 32'h1000 : (32'h1 << i));
      rd(i[0] ? 8'h54 : 8'h40);
      rchk(8'h80, 32'h0);
    end
    // Master starts under each control setting
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {26'h0, req_ctl[i]});
      req(req_rd[i]);
      tick(2);
      rchk(8'h80, {16'h0, req_exp[i]});
      rd(8'h54);
    end
    // Start byte without restart: held until its cause is removed
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 32'hC00);
      wr(8'h00, 32'h01);
      req(1'b0);
      tick(2);
      rchk(8'h80, 32'h200);
      rd(8'h54);
      `CHK("drop", 1'b0, cause_o[9])
      tick(1);
      `CHK("back", 1'b1, cause_o[9])
      rchk(8'h2C, 32'h2);
      wr(fix_a[i], fix_v[i]);
      rd(8'h40);
      rchk(8'h80, 32'h0);
    end
    wr(8'h00, 32'h21);
    wr(8'h04, 32'h0);
    // Interrupt raised, cleared by status read, then masked
    wr(8'h30, 32'h1);
    evt(9'h100);
    tick(2);
    `CHK("irq", 1'b1, irq_o)
    rchk(8'h2C, 32'h1);
    tick(2);
    `CHK("irq", 1'b0, irq_o)
    rd(8'h40);
    wr(8'h30, 32'h0);
    evt(9'h100);
    tick(2);
    `CHK("irq", 1'b0, irq_o)
    rd(8'h40);
    // Read command with empty and with stale transmit data
    slv(5'h03);
    slv(5'h02);
    tick(2);
    rchk(8'h80, 32'h2000);
    rd(8'h54);
    // Data command writes while a remote master waits
    @(posedge core_clk_i) slv_i <= 5'h05;
    wr(8'h10, 32'h0FF);
    wr(8'h10, 32'h100);
    tick(2);
    rchk(8'h80, 32'h8000);
    rd(8'h54);
    // Slave transmit: matching bit, then a bit the bus overrides
    @(posedge core_clk_i) slv_i <= 5'h19;
    itas_bus_model_i.send_bit(1'b1);
    tick(6);
    rchk(8'h80, 32'h0);
    itas_bus_model_i.send_bit(1'b0);
    tick(6);
    rchk(8'h80, 32'h5000);
    @(posedge core_clk_i) slv_i <= 5'h01;
    rd(8'h40);
    rchk(8'h80, 32'h0);
    // Mid-run reset wipes a latched cause and restores the control word
    evt(9'h100);
    @(posedge core_clk_i) nrst_i <= 1'b0;
    tick(2);
    `CHK("reset cause", 16'h0000, cause_o)
    @(posedge core_clk_i) nrst_i <= 1'b1;
    rchk(8'h00, 32'h21);
    rchk(8'h80, 32'h0);
    wrap_up;
  end
endmodule

// File: tb/itas_bus_model.sv
// Remote bus party that clocks single bits onto the pins
`timescale 1ns/1ps
module itas_bus_model (
  // Pins, pulled up when released
  output logic scl_o,
  output logic sda_o
);
  // Idle bus rests high through the pull-ups
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One 300 ns bit after a 5 ns step; the clock stands still after the frame
  task automatic send_bit(input logic b);
    // Step off the core clock edge before touching the pins
    #5 scl_o = 1'b0;
    #50 sda_o = b;
    #50 scl_o = 1'b1;
    #100 scl_o = 1'b0;
    #50 sda_o = 1'b1;
    #50 scl_o = 1'b1;
  endtask
endmodule

// File: tb/itas_checker.sv
// Port checker for the transmit-abort cause block
`timescale 1ns/1ps
module itas_checker (
  // Clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    nrst_i,
  // Register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic [31:0]             rdata_o,
  // Engines
  input  wire itas_pkg::itas_mst_evt_t mst_evt_i,
  input  wire itas_pkg::itas_mst_req_t mst_req_i,
  input  wire itas_pkg::itas_slv_t     slv_i,
  // Results
  input  wire logic                    tx_abort_o,
  input  wire logic [15:0]             cause_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // A clear read at either clear address
  wire logic       clr_rd = rd_i && (addr_i == 8'h54 || addr_i == 8'h40);
  // No cause event at all, so a clear cannot lose to a set
  wire logic       quiet  = !mst_req_i.valid && mst_evt_i == '0 && !slv_i.rd_req && !slv_i.tx_active && !wr_i;
  // Master events as a vector; the low eight map one to one
  wire logic [8:0] ev     = mst_evt_i;
  wire logic [7:0] ev_lo  = ev[7:0];

  property p_rsvd;
    rd_i && addr_i == 8'h80 |=> rdata_o[31:16] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper cause bits not zero");
  property p_clr;
    clr_rd && quiet |=> (cause_o & 16'hFDFF) == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("cause left after clear read");
  property p_b9;
    clr_rd && quiet && cause_o[9] |=> !cause_o[9];
  endproperty
  a_b9: assert property (p_b9) else $error("start byte cause did not drop");
  property p_b15;
    wr_i && addr_i == 8'h10 && wdata_i[8] && slv_i.rd_pending |=> cause_o[15] && tx_abort_o;
  endproperty
  a_b15: assert property (p_b15) else $error("slave read command cause missing");
  property p_b14;
    $rose(cause_o[14]) |-> cause_o[12] && tx_abort_o;
  endproperty
  a_b14: assert property (p_b14) else $error("slave loss without arbitration bit");
  property p_b13;
    slv_i.rd_req && !slv_i.txfifo_empty |=> cause_o[13] && tx_abort_o;
  endproperty
  a_b13: assert property (p_b13) else $error("flush cause missing");
  property p_arb;
    mst_evt_i.arb_lost |=> cause_o[12];
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration cause missing");
  property p_low;
    |ev_lo |=> (cause_o[7:0] & $past(ev_lo)) == $past(ev_lo);
  endproperty
  a_low: assert property (p_low) else $error("master event cause missing");
  property p_latch;
    |(cause_o & ~$past(cause_o) & 16'hFDFF) |-> tx_abort_o;
  endproperty
  a_latch: assert property (p_latch) else $error("cause set without abort pulse");
  property p_hold;
    !clr_rd |=> (cause_o & $past(cause_o)) == $past(cause_o);
  endproperty
  a_hold: assert property (p_hold) else $error("cause lost without clear read");
endmodule

bind itas_abort_cause itas_checker itas_checker_i (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .mst_evt_i, .mst_req_i, .slv_i, .tx_abort_o, .cause_o);
